// File: hdl/cycle_steal_pkg.sv
// Shared constants and types for the cycle-stealing memory port
package cycle_steal_pkg;
    localparam int ADDR_W        = 15;
    localparam int MAIN_ADDR_W   = 13;
    localparam int BANK_W        = 2;
    localparam int WORD_W        = 18;
    localparam int CLK_PERIOD_NS = 50;
    // Machine cycle is 1.75 us; phases one to five at fixed offsets within it
    localparam int CYCLE_NS      = 1750;
    localparam int CYCLE_CYC     = CYCLE_NS / CLK_PERIOD_NS;
    localparam int T1_NS         = 0;
    localparam int T2_NS         = 350;
    localparam int T3_NS         = 700;
    localparam int T5_NS         = 1400;
    localparam int T1_CYC        = T1_NS / CLK_PERIOD_NS;
    localparam int T2_CYC        = T2_NS / CLK_PERIOD_NS;
    localparam int T3_CYC        = T3_NS / CLK_PERIOD_NS;
    localparam int T5_CYC        = T5_NS / CLK_PERIOD_NS;
    // Late sync strobe trails phase five by a fixed delay
    localparam int SYNC_DLY_NS   = 50;
    localparam int SYNC_DLY_CYC  = (SYNC_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LATE_SYNC_CYC = T5_CYC + SYNC_DLY_CYC;
    // Short strobes 70 ns (least, rounded up), data-ready 400 ns
    localparam int SHORT_NS      = 70;
    localparam int SHORT_CYC     = (SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READY_NS      = 400;
    localparam int READY_CYC     = (READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Peripheral may delay capture up to 1 us; must capture by T2+400 ns next cycle
    localparam int CAPT_DLY_NS   = 1000;
    localparam int CAPT_DLY_CYC  = CAPT_DLY_NS / CLK_PERIOD_NS;
    localparam int PH_W          = 6;
    // Wide enough to hold the eight-clock data-ready count
    localparam int CNT_W         = 4;
    localparam logic [WORD_W-1:0] MB_RESET = 18'h0_0000;

    typedef enum logic [1:0] {
        ST_FETCH = 2'b00,
        ST_EXEC  = 2'b01,
        ST_BREAK = 2'b10
    } major_e;
endpackage

// File: hdl/cycle_steal_if.sv
// Link between the processor break port and the peripheral controller
`timescale 1ns/100ps
interface cycle_steal_if;
    import cycle_steal_pkg::*;
    logic                peripheralCycleRequest;
    logic                directionIn;
    logic [ADDR_W-1:0]   breakLocationLines;
    logic [WORD_W-1:0]   breakWordIn;
    logic [WORD_W-1:0]   breakWordOut;
    logic                addressTakenPulse;
    logic                wordTakenPulse;
    logic                dataReadyPulse;

    modport processor (
        input  peripheralCycleRequest, directionIn, breakLocationLines, breakWordIn,
        output breakWordOut, addressTakenPulse, wordTakenPulse, dataReadyPulse
    );
    modport peripheral (
        output peripheralCycleRequest, directionIn, breakLocationLines, breakWordIn,
        input  breakWordOut, addressTakenPulse, wordTakenPulse, dataReadyPulse
    );
endinterface

// File: hdl/cycle_steal_memory_port.sv
// Processor end: cycle timing, request sync, break strobes and memory access
`timescale 1ns/100ps
module cycle_steal_memory_port (
    input  wire logic                            core_clk,
    input  wire logic                            rst_b,
    cycle_steal_if.processor                     link,
    input  wire logic                            instrDone,
    input  wire logic                            interruptBreakSync,
    input  wire logic                            clockBreakSync,
    output logic                                 internalBreakRequest,
    output logic                                 phaseOnePulse,
    output logic                                 phaseTwoPulse,
    output logic                                 phaseThreePulse,
    output logic                                 lateSyncStrobe,
    output logic                                 memWrite,
    output logic                                 memRead,
    output logic [cycle_steal_pkg::MAIN_ADDR_W-1:0] memoryAddressReg,
    output logic [cycle_steal_pkg::BANK_W-1:0]   memoryBankExtension,
    output logic [cycle_steal_pkg::WORD_W-1:0]   memoryBuffer,
    input  wire logic [cycle_steal_pkg::WORD_W-1:0] memReadData,
    output logic                                 breakActive
);
    import cycle_steal_pkg::*;

    logic [PH_W-1:0]  phase;
    logic             requestSync;
    major_e           majorState;
    logic             dataBreak;
    logic [CNT_W-1:0] shortCnt;
    logic [CNT_W-1:0] wordCnt;
    logic [CNT_W-1:0] readyCnt;
    logic             cycleEnd;
    logic             startAddr;
    logic             startWord;
    logic             startReady;
    major_e           next_majorState;

    // Phase decode of the machine cycle counter
    assign cycleEnd        = (phase == PH_W'(CYCLE_CYC - 1));
    assign phaseOnePulse   = (phase == PH_W'(T1_CYC));
    assign phaseTwoPulse   = (phase == PH_W'(T2_CYC));
    assign phaseThreePulse = (phase == PH_W'(T3_CYC));
    assign lateSyncStrobe  = (phase == PH_W'(LATE_SYNC_CYC));

    // Break request to the major state sequencer
    assign internalBreakRequest = requestSync | interruptBreakSync | clockBreakSync;
    // Only a sync-flop break is a memory-access break
    assign dataBreak  = requestSync && (majorState == ST_BREAK);
    assign breakActive = (majorState == ST_BREAK);
    assign startAddr  = dataBreak && phaseOnePulse;
    assign startWord  = dataBreak && phaseThreePulse && link.directionIn;
    assign startReady = dataBreak && phaseThreePulse;

    // Strobes are counter-driven so their widths track the clock rate
    assign link.addressTakenPulse = (shortCnt != '0);
    assign link.wordTakenPulse    = (wordCnt != '0);
    assign link.dataReadyPulse    = (readyCnt != '0);
    assign link.breakWordOut      = memoryBuffer;

    // Memory strobes: write inbound word the clock after phase three, read outbound at phase two
    assign memWrite = dataBreak && link.directionIn && (phase == PH_W'(T3_CYC + 1));
    assign memRead  = dataBreak && !link.directionIn && phaseTwoPulse;

    // Next major state: break follows a completed instruction with a pending request
    always_comb begin
        next_majorState = majorState;
        if (cycleEnd) begin
            if (internalBreakRequest && (instrDone || majorState == ST_BREAK)) begin
                next_majorState = ST_BREAK;
            end else if (instrDone || majorState == ST_BREAK) begin
                next_majorState = ST_FETCH;
            end else begin
                next_majorState = ST_EXEC;
            end
        end
    end

    // Cycle timing and major state
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase      <= '0;
            majorState <= ST_FETCH;
        end else begin
            phase      <= cycleEnd ? '0 : phase + PH_W'(1);
            majorState <= next_majorState;
        end
    end

    // Request sync: sampled only on the late strobe, follows level both ways
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            requestSync <= 1'b0;
        end else if (lateSyncStrobe) begin
            requestSync <= link.peripheralCycleRequest;
        end
    end

    // Pulse width counters
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            shortCnt <= '0;
            wordCnt  <= '0;
            readyCnt <= '0;
        end else begin
            shortCnt <= startAddr  ? CNT_W'(SHORT_CYC) : (shortCnt != '0 ? shortCnt - 1'b1 : '0);
            wordCnt  <= startWord  ? CNT_W'(SHORT_CYC) : (wordCnt != '0 ? wordCnt - 1'b1 : '0);
            readyCnt <= startReady ? CNT_W'(READY_CYC) : (readyCnt != '0 ? readyCnt - 1'b1 : '0);
        end
    end

    // Address and buffer loads; accumulator and program state are not in reach here
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            memoryAddressReg    <= '0;
            memoryBankExtension <= '0;
            memoryBuffer        <= MB_RESET;
        end else begin
            if (startAddr) begin
                memoryAddressReg    <= link.breakLocationLines[MAIN_ADDR_W-1:0];
                memoryBankExtension <= link.breakLocationLines[ADDR_W-1:MAIN_ADDR_W];
            end
            if (startWord) begin
                memoryBuffer <= link.breakWordIn;
            end else if (memRead) begin
                memoryBuffer <= memReadData;
            end
        end
    end
endmodule // cycle_steal_memory_port

// File: hdl/cycle_steal_peripheral.sv
// Peripheral end: raises requests, presents address/word, captures outbound word
`timescale 1ns/100ps
module cycle_steal_peripheral (
    input  wire logic                               core_clk,
    input  wire logic                               rst_b,
    cycle_steal_if.peripheral                       link,
    input  wire logic                               xferValid,
    input  wire logic                               xferIn,
    input  wire logic [cycle_steal_pkg::ADDR_W-1:0] xferAddr,
    input  wire logic [cycle_steal_pkg::WORD_W-1:0] xferWord,
    output logic                                    xferReady,
    output logic                                    rxValid,
    output logic [cycle_steal_pkg::WORD_W-1:0]      rxWord
);
    import cycle_steal_pkg::*;

    logic              pending;
    logic              dirIn;
    logic [ADDR_W-1:0] addrReg;
    logic [WORD_W-1:0] dataReg;
    logic              readyLast;
    logic              readyFall;
    logic              inFlight;

    // Request, direction, address and word all presented together
    assign link.peripheralCycleRequest = pending;
    assign link.directionIn        = dirIn;
    assign link.breakLocationLines = addrReg;
    assign link.breakWordIn        = dataReg;
    // Direction and word must hold until the break's data phase is over
    assign xferReady = !pending && !inFlight;
    // Capture at the trailing edge of data-ready, well within the allowed delay
    assign readyFall = readyLast && !link.dataReadyPulse;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pending   <= 1'b0;
            dirIn     <= 1'b0;
            addrReg   <= '0;
            dataReg   <= '0;
            readyLast <= 1'b0;
            rxValid   <= 1'b0;
            rxWord    <= '0;
            inFlight  <= 1'b0;
        end else begin
            readyLast <= link.dataReadyPulse;
            rxValid   <= 1'b0;
            if (link.addressTakenPulse) begin
                inFlight <= 1'b1;
            end else if (readyFall) begin
                inFlight <= 1'b0;
            end
            if (link.addressTakenPulse) begin
                pending <= 1'b0;
            end else if (xferValid && !pending) begin
                pending <= 1'b1;
                dirIn   <= xferIn;
                addrReg <= xferAddr;
                dataReg <= xferWord;
            end
            if (readyFall && !dirIn) begin
                rxValid <= 1'b1;
                rxWord  <= link.breakWordOut;
            end
        end
    end
endmodule // cycle_steal_peripheral

// File: tb/cycle_steal_sva.sv
// Concurrent checks on the break link between the two ends
`timescale 1ns/100ps
module cycle_steal_checker (
    input wire logic                               core_clk,
    input wire logic                               rst_b,
    input wire logic                               peripheralCycleRequest,
    input wire logic                               directionIn,
    input wire logic [cycle_steal_pkg::WORD_W-1:0] breakWordIn,
    input wire logic [cycle_steal_pkg::WORD_W-1:0] breakWordOut,
    input wire logic                               addressTakenPulse,
    input wire logic                               wordTakenPulse,
    input wire logic                               dataReadyPulse
);
    import cycle_steal_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // Short strobes round 70 ns up to two clocks; data-ready spans eight
    sequence s_twoClk(sig);
        sig ##1 !sig;
    endsequence
    sequence s_eightClk(sig);
        sig[*7] ##1 !sig;
    endsequence
    property p_addrWidth;
        $rose(addressTakenPulse) |=> s_twoClk(addressTakenPulse);
    endproperty
    a_addrWidth: assert property (p_addrWidth) else $error("address pulse width wrong");
    property p_wordWidth;
        $rose(wordTakenPulse) |=> s_twoClk(wordTakenPulse);
    endproperty
    a_wordWidth: assert property (p_wordWidth) else $error("word pulse width wrong");
    property p_readyWidth;
        $rose(dataReadyPulse) |=> s_eightClk(dataReadyPulse);
    endproperty
    a_readyWidth: assert property (p_readyWidth) else $error("ready pulse width wrong");
    // Phase three lies fourteen clocks after phase one
    property p_readyAfterAddr;
        $rose(addressTakenPulse) |-> ##14 $rose(dataReadyPulse);
    endproperty
    a_readyAfterAddr: assert property (p_readyAfterAddr) else $error("ready not at phase three");
    property p_readyNeedsAddr;
        $rose(dataReadyPulse) |-> $past(addressTakenPulse, 14);
    endproperty
    a_readyNeedsAddr: assert property (p_readyNeedsAddr) else $error("ready without break");
    // Late strobe is sampled seven clocks before the address pulse is first seen
    property p_addrNeedsRequest;
        $rose(addressTakenPulse) |-> $past(peripheralCycleRequest, 7);
    endproperty
    a_addrNeedsRequest: assert property (p_addrNeedsRequest) else $error("break without request");
    property p_wordCause;
        $rose(wordTakenPulse) |-> $rose(dataReadyPulse) && directionIn;
    endproperty
    a_wordCause: assert property (p_wordCause) else $error("word pulse out of place");
    property p_inboundTaken;
        $rose(dataReadyPulse) && directionIn |-> $rose(wordTakenPulse);
    endproperty
    a_inboundTaken: assert property (p_inboundTaken) else $error("inbound word not taken");
    property p_inboundLoad;
        $rose(wordTakenPulse) |=> breakWordOut == $past(breakWordIn);
    endproperty
    a_inboundLoad: assert property (p_inboundLoad) else $error("buffer missed inbound word");
    // Outbound word must hold while the peripheral strobes it
    property p_outboundHold;
        $rose(dataReadyPulse) && !directionIn |=> $stable(breakWordOut)[*7];
    endproperty
    a_outboundHold: assert property (p_outboundHold) else $error("outbound word moved");
endmodule // cycle_steal_checker

// File: tb/tb_cycle_steal_memory_port.sv
// Bench joining processor and peripheral ends over one link
`timescale 1ns/100ps
module tb_cycle_steal_memory_port;
    import cycle_steal_pkg::*;
    logic                   core_clk, rst_b, instrDone, interruptBreakSync, clockBreakSync;
    logic                   internalBreakRequest, breakActive, memWrite, memRead;
    logic [MAIN_ADDR_W-1:0] memoryAddressReg;
    logic [BANK_W-1:0]      memoryBankExtension;
    logic [WORD_W-1:0]      memoryBuffer, memReadData, xferWord, rxWord;
    logic                   xferValid, xferIn, xferReady, rxValid;
    logic [ADDR_W-1:0]      xferAddr;
    logic                   phaseOnePulse, phaseTwoPulse, phaseThreePulse, lateSyncStrobe;
    int                     n_mismatch, samples_checked, cycles, nAddr, nDr, nBrk;
    int                     nRd, nWr;
    cycle_steal_if link();
    cycle_steal_memory_port cycle_steal_memory_port_i (.core_clk, .rst_b, .link(link),
        .instrDone, .interruptBreakSync, .clockBreakSync, .internalBreakRequest,
        .phaseOnePulse, .phaseTwoPulse, .phaseThreePulse, .lateSyncStrobe,
        .memWrite, .memRead, .memoryAddressReg, .memoryBankExtension, .memoryBuffer,
        .memReadData, .breakActive);
    cycle_steal_peripheral cycle_steal_peripheral_i (.core_clk, .rst_b, .link(link),
        .xferValid, .xferIn, .xferAddr, .xferWord, .xferReady, .rxValid, .rxWord);
    cycle_steal_checker cycle_steal_checker_i (.core_clk, .rst_b,
        .peripheralCycleRequest(link.peripheralCycleRequest), .directionIn(link.directionIn),
        .breakWordIn(link.breakWordIn), .breakWordOut(link.breakWordOut),
        .addressTakenPulse(link.addressTakenPulse), .wordTakenPulse(link.wordTakenPulse),
        .dataReadyPulse(link.dataReadyPulse));
    // Clock, 50 ns period
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Strobe and break tallies plus hang guard; the run needs well under 3000 clocks
    always @(posedge core_clk) begin
        cycles++;
        nAddr += link.addressTakenPulse === 1'b1;
        nDr   += link.dataReadyPulse === 1'b1;
        nBrk  += breakActive === 1'b1;
        nRd   += memRead === 1'b1;
        nWr   += memWrite === 1'b1;
        if (cycles > 3000) begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic chk(input string what, input logic [WORD_W-1:0] exp, input logic [WORD_W-1:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One user transfer, waited out on the memory write or the received word
    task automatic xfer(input logic in, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] w);
        int i;
        int a0;
        int d0;
        int rd0;
        int wr0;
        a0 = nAddr;
        d0 = nDr;
        rd0 = nRd;
        wr0 = nWr;
        for (i = 0; i < 100 && xferReady !== 1'b1; i++) @(negedge core_clk);
        xferValid = 1'b1;
        xferIn = in;
        xferAddr = a;
        xferWord = w;
        @(negedge core_clk);
        xferValid = 1'b0;
        for (i = 0; i < 120 && (in ? memWrite : rxValid) !== 1'b1; i++) @(negedge core_clk);
        chk("done", 1, in ? memWrite : rxValid);
        chk("main addr", w * 0 + a[12:0], memoryAddressReg);
        chk("bank", a[14:13], memoryBankExtension);
        chk("addr strobe clocks", 2, nAddr - a0);
        // Inbound finishes the clock after phase three; let data-ready run out before counting it
        if (in) repeat (8) @(negedge core_clk);
        chk("ready clocks", 8, nDr - d0);
        chk("mem reads", in ? 0 : 1, nRd - rd0);
        chk("mem writes", in ? 1 : 0, nWr - wr0);
    endtask
    // Inbound then outbound back to back
    task automatic t_pair();
        memReadData = 18'h3_0F0F;
        xfer(1'b1, 15'h5A5C, 18'h2_B3C4);
        chk("inbound buffer", 18'h2_B3C4, memoryBuffer);
        xfer(1'b0, 15'h6001, 18'h0_0000);
        chk("outbound word", 18'h3_0F0F, rxWord);
        chk("outbound buffer", 18'h3_0F0F, memoryBuffer);
    endtask
    // Idle, then interrupt and clock breaks: break state but no strobes
    task automatic t_otherBreaks();
        int s;
        int a0;
        int b0;
        // Let the last data break cycle finish before tallying breaks
        repeat (35) @(negedge core_clk);
        for (s = 0; s < 3; s++) begin
            a0 = nAddr + nDr;
            b0 = nBrk;
            interruptBreakSync = s == 1;
            clockBreakSync = s == 2;
            repeat (70) @(negedge core_clk);
            chk("break request", s != 0, internalBreakRequest);
            chk("break seen", s != 0, nBrk > b0);
            chk("no strobes", 0, nAddr + nDr - a0);
            interruptBreakSync = 1'b0;
            clockBreakSync = 1'b0;
            repeat (70) @(negedge core_clk);
        end
    endtask
    // Phase spacing within one machine cycle, counted from phase one
    task automatic t_timing();
        int n;
        int t2;
        int t3;
        int t5;
        t2 = 0;
        t3 = 0;
        t5 = 0;
        for (n = 0; n < 40 && phaseOnePulse !== 1'b1; n++) @(negedge core_clk);
        for (n = 1; n <= CYCLE_CYC; n++) begin
            @(negedge core_clk);
            if (phaseTwoPulse === 1'b1) t2 = n;
            if (phaseThreePulse === 1'b1) t3 = n;
            if (lateSyncStrobe === 1'b1) t5 = n;
        end
        chk("phase two", T2_CYC, t2);
        chk("phase three", T3_CYC, t3);
        chk("late strobe", LATE_SYNC_CYC, t5);
        chk("cycle length", 1, phaseOnePulse);
    endtask
    task automatic conclude();
        $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Reset for four clocks, then the scenarios
    initial begin
        {rst_b, interruptBreakSync, clockBreakSync, xferValid, xferIn} = 5'h00;
        {instrDone, xferAddr, xferWord, memReadData} = {1'b1, 15'h0000, 36'h0_0000_0000};
        {n_mismatch, samples_checked, cycles, nAddr, nDr, nBrk, nRd, nWr} = '0;
        repeat (4) @(negedge core_clk);
        rst_b = 1'b1;
        t_pair();
        t_otherBreaks();
        t_timing();
        conclude();
    end
endmodule // tb_cycle_steal_memory_port
